// [rtl/icf_capture_flags.sv]
// Three-channel input capture registers, flags and interrupt requests.
//
// The strobed register port and the register addresses were left to the implementer.
`timescale 1ns/10ps
// Notes on behaviour
// R1 - Capture on A loads counter, sets flag A
// R2 - Buffer A moves old A into C first
// R3 - Flags cleared by read-one then write-zero
// R4 - Capture on B loads counter, sets flag B
// R5 - Buffer B moves old B into D
// R6 - Without buffer A, C capture loads C, sets flag
// R7 - Buffer A: pin C sets flag, no load
// R8 - Flag C with enable is external interrupt
// R9 - Request while flag and enable both high
// R10 - Writing one keeps flag; flags reset zero
module icf_capture_flags
    import icf_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic capture_input_pin_a,
    input wire logic capture_input_pin_b,
    input wire logic capture_input_pin_c,
    input wire icf_bus_req_type bus_req,
    output logic [15:0] bus_rdata,
    output icf_irq_type irq
);
    logic [15:0] free_running_counter_reg;
    logic [15:0] free_running_counter_next;
    logic [15:0] capture_reg_a_reg;
    logic [15:0] capture_reg_a_next;
    logic [15:0] capture_reg_b_reg;
    logic [15:0] capture_reg_b_next;
    logic [15:0] capture_reg_c_reg;
    logic [15:0] capture_reg_c_next;
    logic [15:0] capture_reg_d_reg;
    logic [15:0] capture_reg_d_next;
    logic [7:0] timer_control_status_reg;
    logic [7:0] timer_control_status_next;
    logic [7:0] control_reg;
    logic [7:0] control_next;
    logic [7:0] irq_enable_reg;
    logic [7:0] irq_enable_next;
    logic [2:0] flag_seen_reg;
    logic [2:0] flag_seen_next;
    logic [15:0] rdata_reg;
    logic [15:0] rdata_next;
    logic cap_a;
    logic cap_b;
    logic cap_c;
    logic buffer_mode_a_enable;
    logic buffer_mode_b_enable;
    logic [2:0] flag_bits;
    logic [2:0] flag_set;
    logic [2:0] flag_wdata;
    logic status_wr;

    assign buffer_mode_a_enable = control_reg[ICF_BIT_BUF_A];
    assign buffer_mode_b_enable = control_reg[ICF_BIT_BUF_B];

    icf_edge_detect u_edge_a (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .pin(capture_input_pin_a),
        .rise_sel(control_reg[ICF_BIT_EDGE_A]),
        .capture(cap_a)
    );

    icf_edge_detect u_edge_b (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .pin(capture_input_pin_b),
        .rise_sel(control_reg[ICF_BIT_EDGE_B]),
        .capture(cap_b)
    );

    // R7 edge select C
    icf_edge_detect u_edge_c (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .pin(capture_input_pin_c),
        .rise_sel(control_reg[ICF_BIT_EDGE_C]),
        .capture(cap_c)
    );

    assign flag_bits = {timer_control_status_reg[ICF_BIT_FLAG_A],
                        timer_control_status_reg[ICF_BIT_FLAG_B],
                        timer_control_status_reg[ICF_BIT_FLAG_C]};
    assign flag_set = {cap_a, cap_b, cap_c};
    assign flag_wdata = {bus_req.wdata[ICF_BIT_FLAG_A],
                         bus_req.wdata[ICF_BIT_FLAG_B],
                         bus_req.wdata[ICF_BIT_FLAG_C]};
    assign status_wr = bus_req.wr && (bus_req.addr == ICF_OFF_STATUS);

    always_comb begin
        free_running_counter_next = free_running_counter_reg + 16'h0001;
        capture_reg_a_next = capture_reg_a_reg;
        capture_reg_b_next = capture_reg_b_reg;
        capture_reg_c_next = capture_reg_c_reg;
        capture_reg_d_next = capture_reg_d_reg;
        // R1 load register A
        if (cap_a) begin
            capture_reg_a_next = free_running_counter_reg;
        end
        // R2 shift A into C
        if (cap_a && buffer_mode_a_enable) begin
            capture_reg_c_next = capture_reg_a_reg;
        end
        // R6 direct C capture
        if (cap_c && !buffer_mode_a_enable) begin
            capture_reg_c_next = free_running_counter_reg;
        end
        // R4 load register B
        if (cap_b) begin
            capture_reg_b_next = free_running_counter_reg;
        end
        // R5 shift B into D
        if (cap_b && buffer_mode_b_enable) begin
            capture_reg_d_next = capture_reg_b_reg;
        end
    end

    always_comb begin
        timer_control_status_next = timer_control_status_reg;
        control_next = control_reg;
        irq_enable_next = irq_enable_reg;
        flag_seen_next = flag_seen_reg;
        rdata_next = 16'h0000;
        if (bus_req.rd) begin
            unique case (bus_req.addr)
                ICF_OFF_STATUS: begin
                    rdata_next = {8'h00, timer_control_status_reg};
                    // R3 remember flags read as one
                    flag_seen_next = flag_seen_reg | flag_bits;
                end
                ICF_OFF_CONTROL: rdata_next = {8'h00, control_reg};
                ICF_OFF_IRQ_EN: rdata_next = {8'h00, irq_enable_reg};
                ICF_OFF_CAP_A: rdata_next = capture_reg_a_reg;
                ICF_OFF_CAP_B: rdata_next = capture_reg_b_reg;
                ICF_OFF_CAP_C: rdata_next = capture_reg_c_reg;
                ICF_OFF_CAP_D: rdata_next = capture_reg_d_reg;
                ICF_OFF_COUNTER: rdata_next = free_running_counter_reg;
                default: rdata_next = 16'h0000;
            endcase
        end
        if (bus_req.wr && bus_req.addr == ICF_OFF_CONTROL) begin
            control_next = bus_req.wdata[7:0];
        end
        if (bus_req.wr && bus_req.addr == ICF_OFF_IRQ_EN) begin
            irq_enable_next = bus_req.wdata[7:0];
        end
        // R3 clear on zero after read
        // R10 writing one keeps the flag but clears its read-as-one mark in flag_seen_reg
        for (int i = 0; i < 3; i++) begin
            if (status_wr && !flag_wdata[i] && flag_seen_reg[i]) begin
                flag_seen_next[i] = 1'b0;
                timer_control_status_next[ICF_BIT_FLAG_C + i] = 1'b0;
            end else if (status_wr) begin
                flag_seen_next[i] = 1'b0;
            end
        end
        // R1 set flag A
        // R4 set flag B
        // R6 set flag C
        // R7 flag C set in buffer mode
        for (int i = 0; i < 3; i++) begin
            if (flag_set[i]) begin
                timer_control_status_next[ICF_BIT_FLAG_C + i] = 1'b1;
                flag_seen_next[i] = 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            free_running_counter_reg <= ICF_CAP_RESET;
            capture_reg_a_reg <= ICF_CAP_RESET;
            capture_reg_b_reg <= ICF_CAP_RESET;
            capture_reg_c_reg <= ICF_CAP_RESET;
            capture_reg_d_reg <= ICF_CAP_RESET;
            // R10 flags reset to zero
            timer_control_status_reg <= ICF_BYTE_RESET;
            control_reg <= ICF_BYTE_RESET;
            irq_enable_reg <= ICF_BYTE_RESET;
            flag_seen_reg <= 3'h0;
            rdata_reg <= 16'h0000;
        end else begin
            free_running_counter_reg <= free_running_counter_next;
            capture_reg_a_reg <= capture_reg_a_next;
            capture_reg_b_reg <= capture_reg_b_next;
            capture_reg_c_reg <= capture_reg_c_next;
            capture_reg_d_reg <= capture_reg_d_next;
            timer_control_status_reg <= timer_control_status_next;
            control_reg <= control_next;
            irq_enable_reg <= irq_enable_next;
            flag_seen_reg <= flag_seen_next;
            rdata_reg <= rdata_next;
        end
    end

    assign bus_rdata = rdata_reg;
    // R9 request gated by enable
    assign irq.irq_a = timer_control_status_reg[ICF_BIT_FLAG_A]
                       & irq_enable_reg[ICF_BIT_IRQ_A];
    assign irq.irq_b = timer_control_status_reg[ICF_BIT_FLAG_B]
                       & irq_enable_reg[ICF_BIT_IRQ_B];
    // R8 flag C as external interrupt
    assign irq.irq_c = timer_control_status_reg[ICF_BIT_FLAG_C]
                       & irq_enable_reg[ICF_BIT_IRQ_C];
endmodule

// [include/icf_pkg.sv]
// Package with register map, field positions and types of the capture flag block.
package icf_pkg;
    localparam int ICF_ADDR_W = 4;
    localparam logic [3:0] ICF_OFF_STATUS = 4'h0;
    localparam logic [3:0] ICF_OFF_CONTROL = 4'h1;
    localparam logic [3:0] ICF_OFF_IRQ_EN = 4'h2;
    localparam logic [3:0] ICF_OFF_CAP_A = 4'h3;
    localparam logic [3:0] ICF_OFF_CAP_B = 4'h4;
    localparam logic [3:0] ICF_OFF_CAP_C = 4'h5;
    localparam logic [3:0] ICF_OFF_CAP_D = 4'h6;
    localparam logic [3:0] ICF_OFF_COUNTER = 4'h7;
    localparam int ICF_BIT_FLAG_A = 7;
    localparam int ICF_BIT_FLAG_B = 6;
    localparam int ICF_BIT_FLAG_C = 5;
    localparam int ICF_BIT_BUF_A = 3;
    localparam int ICF_BIT_BUF_B = 2;
    localparam int ICF_BIT_EDGE_A = 7;
    localparam int ICF_BIT_EDGE_B = 6;
    localparam int ICF_BIT_EDGE_C = 5;
    localparam int ICF_BIT_IRQ_A = 7;
    localparam int ICF_BIT_IRQ_B = 6;
    localparam int ICF_BIT_IRQ_C = 5;
    localparam logic [15:0] ICF_CAP_RESET = 16'h0000;
    localparam logic [7:0] ICF_BYTE_RESET = 8'h00;

    typedef struct packed {
        logic [ICF_ADDR_W-1:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } icf_bus_req_type;

    typedef struct packed {
        logic irq_a;
        logic irq_b;
        logic irq_c;
    } icf_irq_type;
endpackage

// [rtl/icf_edge_detect.sv]
// Pin synchroniser with selectable edge detection for one capture input.
`timescale 1ns/10ps
module icf_edge_detect (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic pin,
    input wire logic rise_sel,
    output logic capture
);
    logic sync1_reg;
    logic sync2_reg;
    logic prev_reg;
    logic [2:0] state_next;

    always_comb begin
        state_next = {pin, sync1_reg, sync2_reg};
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
            prev_reg <= 1'b0;
        end else begin
            sync1_reg <= state_next[2];
            sync2_reg <= state_next[1];
            prev_reg <= state_next[0];
        end
    end

    // A high edge select picks the rising edge, a low one the falling edge.
    assign capture = rise_sel ? (sync2_reg & ~prev_reg)
                              : (~sync2_reg & prev_reg);
endmodule

// [tb/icf_capture_flags_sva.sv]
// Checker of bus answers and interrupt levels of the capture flag block.
`timescale 1ns/10ps
module icf_capture_flags_sva
    import icf_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic capture_input_pin_a,
    input wire logic capture_input_pin_b,
    input wire logic capture_input_pin_c,
    input wire icf_bus_req_type bus_req,
    input wire logic [15:0] bus_rdata,
    input wire icf_irq_type irq
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    sequence s_rd_st;
        bus_req.rd && bus_req.addr == ICF_OFF_STATUS;
    endsequence
    // A capture landing on the clearing edge wins, so that case is left out.
    sequence s_clr_a;
        bus_req.wr && bus_req.addr == ICF_OFF_STATUS && bus_rdata[7]
            && !bus_req.wdata[7]
            && $past(capture_input_pin_a, 2) == $past(capture_input_pin_a, 3);
    endsequence
    AST_IDLE_DATA: assert property (!$past(bus_req.rd) |-> !bus_rdata)
        else $error("read data outside answer");
    AST_IRQ_A_CAUSE: assert property ($rose(irq.irq_a) |-> $past(bus_req.wr)
        || $past(capture_input_pin_a, 2) != $past(capture_input_pin_a, 5))
        else $error("irq a rose without cause");
    AST_IRQ_B_CAUSE: assert property ($rose(irq.irq_b) |-> $past(bus_req.wr)
        || $past(capture_input_pin_b, 2) != $past(capture_input_pin_b, 5))
        else $error("irq b rose without cause");
    AST_IRQ_C_CAUSE: assert property ($rose(irq.irq_c) |-> $past(bus_req.wr)
        || $past(capture_input_pin_c, 2) != $past(capture_input_pin_c, 5))
        else $error("irq c rose without cause");
    AST_FALL_BY_WRITE: assert property (irq != $past(irq) && !irq
        |-> $past(bus_req.wr)) else $error("irq fell without write");
    AST_CLEAR_A: assert property (s_rd_st ##1 s_clr_a |=> !irq.irq_a)
        else $error("flag a not cleared");
    AST_ONE_KEEPS: assert property (irq.irq_b && bus_req.wr &&
        bus_req.wdata[6] |=> irq.irq_b) else $error("flag b lost");
    AST_READ_FLAG_C: assert property (irq.irq_c && bus_req.rd &&
        bus_req.addr == ICF_OFF_STATUS |=> bus_rdata[5])
        else $error("irq c without flag");
endmodule
bind icf_capture_flags icf_capture_flags_sva u_sva (.ref_clk(ref_clk),
    .rst_n(rst_n), .capture_input_pin_a(capture_input_pin_a),
    .capture_input_pin_b(capture_input_pin_b),
    .capture_input_pin_c(capture_input_pin_c), .bus_req(bus_req),
    .bus_rdata(bus_rdata), .irq(irq));

// [tb/test_icf_capture_flags.sv]
// Directed testbench of the capture flag block.
`timescale 1ns/10ps
module test_icf_capture_flags;
    import icf_pkg::*;
    logic ref_clk;
    logic rst_n;
    logic [2:0] pin;
    icf_bus_req_type bus_req;
    logic [15:0] bus_rdata;
    icf_irq_type irq;
    int miscompares = 0;
    int compares = 0;
    int cycles = 0;
    logic [15:0] v;
    logic [15:0] va;
    logic [15:0] vc;
    icf_capture_flags DUT (.ref_clk(ref_clk), .rst_n(rst_n),
        .capture_input_pin_a(pin[0]), .capture_input_pin_b(pin[1]),
        .capture_input_pin_c(pin[2]), .bus_req(bus_req),
        .bus_rdata(bus_rdata), .irq(irq));
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h not %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic [3:0] a, input logic [15:0] d,
        input logic w, input logic r);
        bus_req <= '{addr: a, wdata: d, wr: w, rd: r};
        @(posedge ref_clk);
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        bus(a, d, 1'b1, 1'b0);
        bus(4'h0, 16'h0000, 1'b0, 1'b0);
    endtask
    // A read, followed at once by a zero write to status when clr is set.
    task automatic rd(input logic [3:0] a, input logic clr,
        output logic [15:0] q);
        bus(a, 16'h0000, 1'b0, 1'b1);
        bus(ICF_OFF_STATUS, 16'h0000, clr, 1'b0);
        q = bus_rdata;
        bus(4'h0, 16'h0000, 1'b0, 1'b0);
    endtask
    task automatic pulse(input int ch);
        pin[ch] <= 1'b1;
        repeat (6) @(posedge ref_clk);
        pin[ch] <= 1'b0;
        repeat (6) @(posedge ref_clk);
    endtask
    task automatic test_reset();
        for (int i = 0; i < 9; i++) begin
            rd(i[3:0], 1'b0, v);
            // Index 7 is the counter: it runs from release, three clocks a read.
            chk(v, (i == 7) ? 16'(3 * i) : 16'h0000);
        end
        $display("test_reset done");
    endtask
    task automatic test_flag_a();
        wr(ICF_OFF_CONTROL, 16'h00e0);
        wr(ICF_OFF_IRQ_EN, 16'h00e0);
        rd(ICF_OFF_COUNTER, 1'b0, va);
        pulse(0);
        chk({13'h0, irq}, 16'h0004);
        rd(ICF_OFF_CAP_A, 1'b0, v);
        chk({15'h0, v > va && v < va + 16'd40}, 16'h0001);
        rd(ICF_OFF_STATUS, 1'b0, v);
        wr(ICF_OFF_STATUS, 16'h00e0);
        chk({13'h0, irq}, 16'h0004);
        wr(ICF_OFF_STATUS, 16'h0000);
        chk({13'h0, irq}, 16'h0004);
        rd(ICF_OFF_STATUS, 1'b1, v);
        chk(v, 16'h0080);
        chk({13'h0, irq}, 16'h0000);
        $display("test_flag_a done");
    endtask
    task automatic test_buffer();
        wr(ICF_OFF_CONTROL, 16'h00ec);
        rd(ICF_OFF_CAP_A, 1'b0, va);
        pulse(0);
        rd(ICF_OFF_CAP_C, 1'b0, vc);
        chk(vc, va);
        pulse(1);
        rd(ICF_OFF_CAP_D, 1'b0, v);
        chk(v, 16'h0000);
        rd(ICF_OFF_CAP_B, 1'b0, va);
        pulse(1);
        rd(ICF_OFF_CAP_D, 1'b0, v);
        chk(v, va);
        pulse(2);
        rd(ICF_OFF_CAP_C, 1'b0, v);
        chk(v, vc);
        chk({13'h0, irq}, 16'h0007);
        wr(ICF_OFF_STATUS, 16'h00e0);
        chk({13'h0, irq}, 16'h0007);
        rd(ICF_OFF_STATUS, 1'b1, v);
        chk(v, 16'h00e0);
        chk({13'h0, irq}, 16'h0000);
        $display("test_buffer done");
    endtask
    task automatic test_plain_c();
        wr(ICF_OFF_CONTROL, 16'h00e0);
        pulse(2);
        rd(ICF_OFF_CAP_C, 1'b0, v);
        chk({15'h0, v > vc}, 16'h0001);
        rd(ICF_OFF_STATUS, 1'b0, v);
        chk(v, 16'h0020);
        wr(ICF_OFF_IRQ_EN, 16'h0000);
        chk({13'h0, irq}, 16'h0000);
        $display("test_plain_c done");
    endtask
    // Falling edge selected on C in buffer mode: the rising edge is ignored.
    task automatic test_edge_c();
        rd(ICF_OFF_STATUS, 1'b1, v);
        chk(v, 16'h0020);
        wr(ICF_OFF_IRQ_EN, 16'h0020);
        wr(ICF_OFF_CONTROL, 16'h0008);
        pin[2] <= 1'b1;
        repeat (6) @(posedge ref_clk);
        chk({13'h0, irq}, 16'h0000);
        pin[2] <= 1'b0;
        repeat (6) @(posedge ref_clk);
        chk({13'h0, irq}, 16'h0001);
        rd(ICF_OFF_STATUS, 1'b1, v);
        chk(v, 16'h0020);
        chk({13'h0, irq}, 16'h0000);
        $display("test_edge_c done");
    endtask
    task automatic test_done();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 3000) begin
            miscompares++;
            test_done();
        end
    end
    initial begin
        rst_n = 1'b0;
        pin = 3'b000;
        bus_req = '0;
        repeat (6) @(posedge ref_clk);
        rst_n <= 1'b1;
        test_reset();
        test_flag_a();
        test_buffer();
        test_plain_c();
        test_edge_c();
        test_done();
    end
endmodule
